// ==== rtl/spd_top.sv ====
// Two-channel stepping motor drive pulse generator with Wishbone slave.
// Assumes a synchronous Wishbone master on core_clk and motor coil
// terminals driven directly from the drive outputs (active high).
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps

module spd_top #(
  parameter logic [17:0] STEP_SHORT = spd_pkg::STEP_SHORT_CYC,
  parameter logic [17:0] STEP_LONG  = spd_pkg::STEP_LONG_CYC
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Wishbone slave
  input  wire spd_pkg::spd_wb_req_t wbReq,
  output spd_pkg::spd_wb_rsp_t      wbRsp,
  // Motor terminals and interrupt
  output spd_pkg::spd_drv_t         motorDrv,
  output logic                      irq
);
  import spd_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic            ack;
    logic [3:0]      rdat;
    logic [1:0]      busy;
    logic [1:0]      term;
    logic [1:0][4:0] width;
    logic            baseSel;
    logic [1:0]      irqEn;
    logic [1:0]      flags;
    logic [1:0][17:0] stepCnt;
    logic [1:0][4:0] tickCnt;
    logic [1:0][1:0] drv;
    logic            irq;
  } spd_state_t;

  spd_state_t  s_q;
  spd_state_t  s_d;
  logic        busReq;
  logic        wrEn;
  logic        clrWr;
  logic [15:0] idx;
  logic [3:0]  wdat;
  logic [1:0]  done;
  logic [17:0] stepLen;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] eff_steps(input logic [4:0] code);
    logic [4:0] c;
    c = (code >= SAT_CODE) ? SAT_VALUE : code;
    return 5'(BASE_STEPS + c);
  endfunction : eff_steps

  function automatic logic [3:0] read_mux(input logic [15:0] a,
                                          input spd_state_t st);
    logic [3:0] r;
    r = 4'h0;
    if (a == IDX_TRIG) begin
      r = {2'h0, st.busy};
    end else if (a == IDX_W1HI) begin
      r = {3'h0, st.width[0][WIDTH_MSB]};
    end else if (a == IDX_W1LO) begin
      r = st.width[0][3:0];
    end else if (a == IDX_W2HI) begin
      r = {3'h0, st.width[1][WIDTH_MSB]};
    end else if (a == IDX_W2LO) begin
      r = st.width[1][3:0];
    end else if (a == IDX_BASE) begin
      r = {3'h0, st.baseSel};
    end else if (a == IDX_IRQEN) begin
      r = {2'h0, st.irqEn};
    end else if (a == IDX_FLAGS) begin
      r = {2'h0, st.flags};
    end
    return r;
  endfunction : read_mux

  // ****************************************
  // Bus decode
  // ****************************************
  assign busReq  = wbReq.cyc & wbReq.stb;
  assign wrEn    = busReq & s_q.ack & wbReq.we & wbReq.sel[0];
  assign clrWr   = wrEn & ((idx == IDX_FLAGS) | (idx == IDX_FLCLR));
  assign idx     = wbReq.adr[ADR_W-1:2];
  assign wdat    = wbReq.dat[3:0];
  assign stepLen = s_q.baseSel ? STEP_SHORT : STEP_LONG;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      done[c] = s_q.busy[c] & (s_q.tickCnt[c] == 5'h01) &
                (s_q.stepCnt[c] == 18'h00001);
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d     = s_q;
    s_d.ack = busReq & ~s_q.ack;
    if (busReq & ~s_q.ack) begin
      s_d.rdat = read_mux(idx, s_q);
    end
    // Configuration writes
    if (wrEn) begin
      if (idx == IDX_W1HI) begin
        s_d.width[0][WIDTH_MSB] = wdat[0];
      end else if (idx == IDX_W1LO) begin
        s_d.width[0][3:0] = wdat;
      end else if (idx == IDX_W2HI) begin
        s_d.width[1][WIDTH_MSB] = wdat[0];
      end else if (idx == IDX_W2LO) begin
        s_d.width[1][3:0] = wdat;
      end else if (idx == IDX_BASE) begin
        s_d.baseSel = wdat[0];
      end else if (idx == IDX_IRQEN) begin
        s_d.irqEn = wdat[1:0];
      end
    end
    // Per-channel pulse engine
    for (int c = 0; c < 2; c++) begin
      if (s_q.busy[c]) begin
        if (s_q.stepCnt[c] == 18'h00001) begin
          s_d.stepCnt[c] = stepLen;
          s_d.tickCnt[c] = s_q.tickCnt[c] - 5'h01;
        end else begin
          s_d.stepCnt[c] = s_q.stepCnt[c] - 18'h00001;
        end
      end
      if (done[c]) begin
        s_d.busy[c] = 1'b0;
        s_d.term[c] = ~s_q.term[c];
      end
      // Trigger ignored while busy
      if (wrEn && idx == IDX_TRIG && wdat[c] && !s_q.busy[c]) begin
        s_d.busy[c]    = 1'b1;
        s_d.tickCnt[c] = eff_steps(s_q.width[c]);
        s_d.stepCnt[c] = stepLen;
      end
      s_d.drv[c] = {s_d.busy[c] & s_d.term[c],
                    s_d.busy[c] & ~s_d.term[c]};
    end
    // Flags: completion wins over a clear in the same cycle
    if (clrWr) begin
      s_d.flags = s_q.flags & ~wdat[1:0];
    end
    s_d.flags = s_d.flags | done;
    s_d.irq   = |(s_d.flags & s_d.irqEn);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wbRsp.ack          = s_q.ack;
  assign wbRsp.dat          = {28'h0000000, s_q.rdat};
  assign motorDrv.ch1_out_a = s_q.drv[0][0];
  assign motorDrv.ch1_out_b = s_q.drv[0][1];
  assign motorDrv.ch2_out_a = s_q.drv[1][0];
  assign motorDrv.ch2_out_b = s_q.drv[1][1];
  assign irq                = s_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  for (genvar g = 0; g < 2; g++) begin : g_chk
    sequence s_trig;
      wrEn && idx == IDX_TRIG && wdat[g];
    endsequence

    sequence s_start;
      s_trig and !s_q.busy[g];
    endsequence

    property p_startBusy;
      @(posedge core_clk) disable iff (rst)
        s_start |=> s_q.busy[g] && s_q.drv[g] != 2'h0;
    endproperty
    a_startBusy : assert property (p_startBusy)
      else $error("trigger did not start pulse");

    property p_zeroWrite;
      @(posedge core_clk) disable iff (rst)
        wrEn && idx == IDX_TRIG && !wdat[g] && !s_q.busy[g]
        |=> !s_q.busy[g];
    endproperty
    a_zeroWrite : assert property (p_zeroWrite)
      else $error("zero write started pulse");

    property p_ignoreBusy;
      @(posedge core_clk) disable iff (rst)
        s_trig and s_q.busy[g] && !done[g]
        |=> s_q.tickCnt[g] <= $past(s_q.tickCnt[g]);
    endproperty
    a_ignoreBusy : assert property (p_ignoreBusy)
      else $error("busy pulse restarted");

    property p_loadWidth;
      @(posedge core_clk) disable iff (rst)
        s_start |=> s_q.tickCnt[g] == eff_steps($past(s_q.width[g]))
                 && s_q.stepCnt[g] == $past(stepLen);
    endproperty
    a_loadWidth : assert property (p_loadWidth)
      else $error("pulse length loaded wrong");

    property p_doneFlag;
      @(posedge core_clk) disable iff (rst)
        done[g] |=> !s_q.busy[g] && s_q.flags[g] && s_q.drv[g] == 2'h0;
    endproperty
    a_doneFlag : assert property (p_doneFlag)
      else $error("completion did not set flag");

    property p_alternate;
      @(posedge core_clk) disable iff (rst)
        done[g] |=> s_q.term[g] != $past(s_q.term[g]);
    endproperty
    a_alternate : assert property (p_alternate)
      else $error("terminal did not alternate");

    property p_idleQuiet;
      @(posedge core_clk) disable iff (rst)
        !s_q.busy[g] |-> s_q.drv[g] == 2'h0;
    endproperty
    a_idleQuiet : assert property (p_idleQuiet)
      else $error("terminal driven while idle");

    property p_clearFlag;
      @(posedge core_clk) disable iff (rst)
        wrEn && (idx == IDX_FLAGS || idx == IDX_FLCLR) && wdat[g]
        && !done[g] |=> !s_q.flags[g];
    endproperty
    a_clearFlag : assert property (p_clearFlag)
      else $error("flag not cleared");

    sequence s_run;
      s_q.busy[g] && !done[g];
    endsequence

    property p_busyHold;
      @(posedge core_clk) disable iff (rst)
        s_run |=> s_q.busy[g];
    endproperty
    a_busyHold : assert property (p_busyHold)
      else $error("busy dropped before completion");

    property p_stepDown;
      @(posedge core_clk) disable iff (rst)
        s_run ##0 s_q.stepCnt[g] != 18'h00001
        |=> s_q.stepCnt[g] == $past(s_q.stepCnt[g]) - 18'h00001
         && s_q.tickCnt[g] == $past(s_q.tickCnt[g]);
    endproperty
    a_stepDown : assert property (p_stepDown)
      else $error("step counter did not count down");

    property p_stepReload;
      @(posedge core_clk) disable iff (rst)
        s_run ##0 s_q.stepCnt[g] == 18'h00001
        |=> s_q.stepCnt[g] == $past(stepLen)
         && s_q.tickCnt[g] == $past(s_q.tickCnt[g]) - 5'h01;
    endproperty
    a_stepReload : assert property (p_stepReload)
      else $error("step not reloaded");

    property p_driveSel;
      @(posedge core_clk) disable iff (rst)
        s_q.busy[g] |-> s_q.drv[g] == (s_q.term[g] ? 2'h2 : 2'h1);
    endproperty
    a_driveSel : assert property (p_driveSel)
      else $error("wrong terminal driven");

    property p_termHold;
      @(posedge core_clk) disable iff (rst)
        !done[g] |=> s_q.term[g] == $past(s_q.term[g]);
    endproperty
    a_termHold : assert property (p_termHold)
      else $error("terminal changed without completion");

    property p_flagHold;
      @(posedge core_clk) disable iff (rst)
        s_q.flags[g] && !(clrWr && wdat[g]) |=> s_q.flags[g];
    endproperty
    a_flagHold : assert property (p_flagHold)
      else $error("flag lost without clear");

    property p_flagCause;
      @(posedge core_clk) disable iff (rst)
        !s_q.flags[g] && !done[g] |=> !s_q.flags[g];
    endproperty
    a_flagCause : assert property (p_flagCause)
      else $error("flag set without completion");

    property p_widthLow;
      @(posedge core_clk) disable iff (rst)
        wrEn && idx == (g == 0 ? IDX_W1LO : IDX_W2LO)
        |=> s_q.width[g][3:0] == $past(wdat);
    endproperty
    a_widthLow : assert property (p_widthLow)
      else $error("low width bits not written");

    property p_widthHigh;
      @(posedge core_clk) disable iff (rst)
        wrEn && idx == (g == 0 ? IDX_W1HI : IDX_W2HI)
        |=> s_q.width[g][WIDTH_MSB] == $past(wdat[0]);
    endproperty
    a_widthHigh : assert property (p_widthHigh)
      else $error("high width bit not written");
  end

  property p_irqLevel;
    @(posedge core_clk) disable iff (rst)
      irq == (|(s_q.flags & s_q.irqEn));
  endproperty
  a_irqLevel : assert property (p_irqLevel)
    else $error("interrupt not asserted");

  property p_busyRead;
    @(posedge core_clk) disable iff (rst)
      busReq && !s_q.ack && idx == IDX_TRIG
      |=> wbRsp.ack && wbRsp.dat[1:0] == $past(s_q.busy);
  endproperty
  a_busyRead : assert property (p_busyRead)
    else $error("busy read mismatch");

  property p_baseWrite;
    @(posedge core_clk) disable iff (rst)
      wrEn && idx == IDX_BASE |=> s_q.baseSel == $past(wdat[0]);
  endproperty
  a_baseWrite : assert property (p_baseWrite)
    else $error("base clock select not written");

  property p_baseHold;
    @(posedge core_clk) disable iff (rst)
      !(wrEn && idx == IDX_BASE) |=> $stable(s_q.baseSel);
  endproperty
  a_baseHold : assert property (p_baseHold)
    else $error("base clock select changed");

  property p_enWrite;
    @(posedge core_clk) disable iff (rst)
      wrEn && idx == IDX_IRQEN |=> s_q.irqEn == $past(wdat[1:0]);
  endproperty
  a_enWrite : assert property (p_enWrite)
    else $error("interrupt enable not written");

  property p_enHold;
    @(posedge core_clk) disable iff (rst)
      !(wrEn && idx == IDX_IRQEN) |=> $stable(s_q.irqEn);
  endproperty
  a_enHold : assert property (p_enHold)
    else $error("interrupt enable changed");

endmodule : spd_top

// ==== pkg/spd_pkg.sv ====
// Package of the stepper pulse driver: register map, field layout,
// timing constants and the carrier structs of the bus and motor pins.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone master.
package spd_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam int          ADR_W      = 18;
  localparam logic [15:0] IDX_TRIG   = 16'hFF10;
  localparam logic [15:0] IDX_W1HI   = 16'hFF11;
  localparam logic [15:0] IDX_W1LO   = 16'hFF12;
  localparam logic [15:0] IDX_W2HI   = 16'hFF13;
  localparam logic [15:0] IDX_W2LO   = 16'hFF14;
  localparam logic [15:0] IDX_BASE   = 16'hFF15;
  localparam logic [15:0] IDX_IRQEN  = 16'hFFE8;
  localparam logic [15:0] IDX_FLAGS  = 16'hFFF8;
  localparam logic [15:0] IDX_FLCLR  = 16'hFFF9;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          CH1_BIT    = 0;
  localparam int          CH2_BIT    = 1;
  localparam int          WIDTH_MSB  = 4;
  localparam logic [4:0]  WIDTH_RST  = 5'h00;
  localparam logic        BASE_RST   = 1'h0;
  localparam logic [1:0]  IRQEN_RST  = 2'h0;
  localparam logic [1:0]  FLAGS_RST  = 2'h0;

  // ****************************************
  // Pulse timing
  // ****************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STEP_SHORT_NS = 244000;
  localparam int          STEP_LONG_NS  = 1953000;
  localparam logic [17:0] STEP_SHORT_CYC =
    18'(STEP_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [17:0] STEP_LONG_CYC =
    18'(STEP_LONG_NS / CLK_PERIOD_NS);
  localparam logic [4:0]  BASE_STEPS = 5'h06;
  localparam logic [4:0]  SAT_CODE   = 5'h18;
  localparam logic [4:0]  SAT_VALUE  = 5'h08;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } spd_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } spd_wb_rsp_t;

  typedef struct packed {
    logic ch2_out_b;
    logic ch2_out_a;
    logic ch1_out_b;
    logic ch1_out_a;
  } spd_drv_t;

endpackage : spd_pkg

// ==== verif/spd_coil_model.sv ====
// Coil model of the stepper pulse driver: measures each drive pulse.
// Assumes active-high terminals, sampled on the core clock.
`timescale 1ns/100ps
module spd_coil_model (
  // Clock and coil terminals
  input  wire logic              core_clk,
  input  wire spd_pkg::spd_drv_t motorDrv,
  // Last pulse seen
  output int                     pulseLen,
  output logic [3:0]             pulseTerm,
  output int                     pulseCnt
);
  import spd_pkg::*;
  // ****************************************
  // Pulse measurement
  // ****************************************
  int         run  = 0;
  logic [3:0] prev = 4'h0;
  initial pulseCnt = 0;
  always @(posedge core_clk) begin
    if (motorDrv != 4'h0) begin
      run       <= run + 1;
      pulseTerm <= motorDrv;
    end else if (prev != 4'h0) begin
      pulseLen <= run;
      pulseCnt <= pulseCnt + 1;
      run      <= 0;
    end
    prev <= motorDrv;
  end
endmodule : spd_coil_model

// ==== verif/stepper_pulse_driver_test.sv ====
// Bench of the stepper pulse driver: registers, pulses, interrupt.
// Assumes spd_top with short step counts and the coil model beside it.
`timescale 1ns/100ps
module stepper_pulse_driver_test;
  import spd_pkg::*;
  // ****************************************
  // Signals and cases
  // ****************************************
  typedef struct {logic ch; logic bs; logic [4:0] cd;
                  logic [4:0] st;} spd_row_t;
  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  spd_wb_req_t wbReq       = '0;
  spd_wb_rsp_t wbRsp;
  spd_drv_t    motorDrv;
  logic        irq;
  logic [3:0]  pulseTerm;
  logic [31:0] rd;
  logic [1:0]  side        = 2'h0;
  int          pulseLen;
  int          pulseCnt;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          n;
  spd_row_t    rows [6]    = '{'{1'b0, 1'b0, 5'h00, 5'h06},
    '{1'b1, 1'b1, 5'h01, 5'h07}, '{1'b0, 1'b1, 5'h08, 5'h0E},
    '{1'b1, 1'b0, 5'h17, 5'h1D}, '{1'b0, 1'b1, 5'h18, 5'h0E},
    '{1'b1, 1'b0, 5'h1F, 5'h0E}};
  logic [15:0] regs [10]   = '{IDX_TRIG, IDX_W1HI, IDX_W1LO, IDX_W2HI,
    IDX_W2LO, IDX_BASE, IDX_IRQEN, IDX_FLAGS, 16'h0100, IDX_FLCLR};

  spd_top #(.STEP_SHORT(18'h00004), .STEP_LONG(18'h00007)) u_spd_top (
    .core_clk (core_clk), .rst (rst), .wbReq (wbReq), .wbRsp (wbRsp),
    .motorDrv (motorDrv), .irq (irq));
  spd_coil_model u_spd_coil_model (.core_clk (core_clk),
    .motorDrv (motorDrv), .pulseLen (pulseLen), .pulseTerm (pulseTerm),
    .pulseCnt (pulseCnt));

  always #5 core_clk = ~core_clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic wb(logic we, logic [15:0] idx, logic [3:0] d);
    @(posedge core_clk);
    wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {28'h0, d}};
    do @(posedge core_clk); while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge core_clk);
  endtask : wb

  task automatic rdchk(string nm, logic [15:0] idx, logic [3:0] e);
    wb(1'b0, idx, 4'h0);
    check(nm, rd, {28'h0, e});
  endtask : rdchk

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask : settle

  task automatic pulse(logic ch, logic bs, logic [4:0] cd,
                       logic [4:0] st);
    int len;
    len = st * (bs ? 32'h4 : 32'h7);
    n = pulseCnt;
    wb(1'b1, ch ? IDX_W2HI : IDX_W1HI, {3'h0, cd[4]});
    wb(1'b1, ch ? IDX_W2LO : IDX_W1LO, cd[3:0]);
    wb(1'b1, IDX_BASE, {3'h0, bs});
    wb(1'b1, IDX_TRIG, {2'h0, ch, !ch});
    rdchk("busy", IDX_TRIG, {2'h0, ch, !ch});
    wb(1'b1, IDX_TRIG, 4'h3 & {2'h0, ch, !ch});
    while (pulseCnt == n) @(posedge core_clk);
    check("len", pulseLen, len);
    check("term", pulseTerm, 4'h1 << {ch, side[ch]});
    side[ch] = !side[ch];
    rdchk("idle", IDX_TRIG, 4'h0);
    rdchk("flag", IDX_FLAGS, {2'h0, ch, !ch});
    check("off", motorDrv, 4'h0);
  endtask : pulse

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    foreach (regs[i]) rdchk("rst", regs[i], 4'h0);
    wb(1'b1, IDX_W1HI, 4'hF);
    rdchk("w1hi", IDX_W1HI, 4'h1);
    wb(1'b1, IDX_IRQEN, 4'hF);
    rdchk("en", IDX_IRQEN, 4'h3);
    wb(1'b1, IDX_IRQEN, 4'h0);
    foreach (rows[i]) begin
      pulse(rows[i].ch, rows[i].bs, rows[i].cd, rows[i].st);
      wb(1'b1, IDX_FLAGS, 4'h3);
    end
    n = pulseCnt;
    wb(1'b1, IDX_TRIG, 4'h0);
    settle();
    check("nop", pulseCnt, n);
    wb(1'b1, IDX_IRQEN, 4'h1);
    pulse(1'b0, 1'b1, 5'h02, 5'h08);
    settle();
    check("irq", irq, 1'b1);
    wb(1'b1, IDX_IRQEN, 4'h0);
    settle();
    check("mask", irq, 1'b0);
    wb(1'b1, IDX_IRQEN, 4'h1);
    wb(1'b1, IDX_FLAGS, 4'h0);
    settle();
    check("again", irq, 1'b1);
    wb(1'b1, IDX_FLCLR, 4'h1);
    settle();
    check("clr", irq, 1'b0);
    rdchk("flag0", IDX_FLAGS, 4'h0);
    wb(1'b1, IDX_TRIG, 4'h1);
    repeat (3) @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("rstdrv", motorDrv, 4'h0);
    rst <= 1'b0;
    side = 2'h0;
    pulse(1'b0, 1'b0, 5'h03, 5'h09);
    print_verdict();
  end
endmodule : stepper_pulse_driver_test
